// >>> hw/mqd_pkg.sv
package mqd_pkg;
  localparam int NQ        = 16;   // Qudit slots
  localparam int NI        = 16;   // Integrators in the channel
  localparam int NB        = 16;   // Link output bit positions
  localparam int DW        = 16;   // Integrator and threshold width
  localparam int MAW       = 12;   // Store word address width
  localparam int NEV       = 3;    // Interrupt events
  localparam int PCT_SCALE = 100;  // Percent scale
  localparam int CTRL_MS   = 0;    // Control: multi-state mode
  localparam int CTRL_PK   = 1;    // Control: compact packing
  localparam int EV_DONE   = 0;    // Result delivered
  localparam int EV_REFUSE = 1;    // Trigger refused, bad config
  localparam int EV_DROP   = 2;    // Trigger dropped, engine busy
  localparam int MEM_BIT   = 14;   // Address bit selecting the store

  localparam logic [3:0] QS_MIN       = 4'h2;
  localparam logic [3:0] QS_MAX       = 4'h4;
  localparam logic [5:0] SRC_HI_FIRST = 6'h10;
  localparam logic [5:0] SRC_FIX0     = 6'h20;
  localparam logic [5:0] SRC_FIX1     = 6'h21;

  // Register byte offsets
  localparam logic [15:0] A_CTRL  = 16'h0000;
  localparam logic [15:0] A_QEN   = 16'h0004;
  localparam logic [15:0] A_NS_LO = 16'h0008;
  localparam logic [15:0] A_NS_HI = 16'h000c;
  localparam logic [15:0] A_CNT   = 16'h0010;
  localparam logic [15:0] A_PCT   = 16'h0014;
  localparam logic [15:0] A_AVAIL = 16'h0018;
  localparam logic [15:0] A_VALID = 16'h001c;
  localparam logic [15:0] A_ISTAT = 16'h0020;
  localparam logic [15:0] A_IMASK = 16'h0024;
  localparam logic [15:0] A_RES   = 16'h0028;
  localparam logic [5:0]  P_QINFO = 6'h04;   // 0x100 + 4*qudit
  localparam logic [5:0]  P_SRC   = 6'h08;   // 0x200 + 4*bit

  // Store regions
  localparam logic [1:0] MR_THR = 2'h0;
  localparam logic [1:0] MR_ASG = 2'h1;
  localparam logic [1:0] MR_WGT = 2'h2;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  typedef enum logic [2:0] {E_IDLE, E_NEXT, E_THR, E_CMP, E_ASG, E_AWT, E_OUT} mqd_eng_t;
  typedef enum logic [1:0] {R_IDLE, R_DEC, R_WAIT, R_RESP} mqd_rph_t;

  // Thresholds used for d states: d(d-1)/2
  function automatic logic [2:0] n_thr(input logic [3:0] d);
    return 3'(({2'h0, d} * ({2'h0, d} - 6'h1)) >> 1);
  endfunction

  // Integrators (weight waves) used: d-1
  function automatic logic [1:0] need(input logic [3:0] d);
    return 2'(d - 4'h1);
  endfunction

  // Packed link bits per qudit
  function automatic logic [1:0] nbits(input logic [3:0] d);
    return (d == QS_MIN) ? 2'h1 : 2'h2;
  endfunction

  // Integrator offset compared by threshold k
  function automatic logic [1:0] thr_src(input logic [3:0] d, input logic [2:0] k);
    return 2'(k % (3'(d) - 3'h1));
  endfunction

  function automatic logic [MAW-1:0] mem_a(input logic [3:0] q, input logic [1:0] rg,
                                          input logic [5:0] i);
    return {q, rg, i};
  endfunction

  function automatic logic is_page(input logic [15:0] a, input logic [5:0] p);
    return a[15:12] == 4'h0 && a[11:6] == p;
  endfunction
endpackage // mqd_pkg

// >>> hw/mqd_mem_if.sv
`timescale 1ns/100ps
interface mqd_mem_if;
  import mqd_pkg::*;
  logic           we;
  logic [MAW-1:0] addr;
  logic [DW-1:0]  wdata;
  logic [DW-1:0]  rdata;
  modport ctl (output we, addr, wdata, input rdata);
  modport mem (input we, addr, wdata, output rdata);
endinterface // mqd_mem_if

// >>> hw/mqd_store.sv
`timescale 1ns/100ps
module mqd_store
  import mqd_pkg::*;
(
  input wire logic sys_clk_in,
  mqd_mem_if.mem   port
);
  logic [DW-1:0] ram [0:(1 << MAW) - 1];
  logic [DW-1:0] rd_r;

  // Single port, registered read
  always_ff @(posedge sys_clk_in) begin
    if (port.we) begin
      ram[port.addr] <= port.wdata;
    end
    rd_r <= ram[port.addr];
  end

  assign port.rdata = rd_r;
endmodule // mqd_store

// >>> hw/mqd_top.sv
// Our own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/100ps
// Function
// - Packed mode: qudit bits ascending, 1 or 2
// - Packed mode blocks bit source writes
// - Global multi-state mode enable
// - Read-only integrator count in use
// - Read-only integrator usage percentage
// - Per-qudit flag: enough integrators free
// - Per-qudit enable request
// - Per-qudit allocated integrator list
// - Per-qudit first integrator index
// - State count limited to 2..4
// - Only first d(d-1)/2 thresholds used
// - Complex weights, first d-1 waves used
// - Valid flag: enabled qudits fit integrators
// - Source selector per link bit
// - Code 2q+b selects qudit q bit b
// - Codes 16..31 only on larger build
module mqd_top
  import mqd_pkg::*;
#(
  parameter logic LARGE_CFG = 1'b0
) (
  input  wire logic             sys_clk_in,
  input  wire logic             srst_in,
  input  wire logic [15:0]      s_axi_awaddr_in,
  input  wire logic             s_axi_awvalid_in,
  output logic                  s_axi_awready_out,
  input  wire logic [31:0]      s_axi_wdata_in,
  input  wire logic [3:0]       s_axi_wstrb_in,
  input  wire logic             s_axi_wvalid_in,
  output logic                  s_axi_wready_out,
  output logic [1:0]            s_axi_bresp_out,
  output logic                  s_axi_bvalid_out,
  input  wire logic             s_axi_bready_in,
  input  wire logic [15:0]      s_axi_araddr_in,
  input  wire logic             s_axi_arvalid_in,
  output logic                  s_axi_arready_out,
  output logic [31:0]           s_axi_rdata_out,
  output logic [1:0]            s_axi_rresp_out,
  output logic                  s_axi_rvalid_out,
  input  wire logic             s_axi_rready_in,
  input  wire logic [NI*DW-1:0] int_val_in,
  input  wire logic             int_valid_in,
  output logic [NB-1:0]         link_bits_out,
  output logic                  link_strobe_out,
  output logic                  irq_out
);
  typedef struct packed {
    logic             awrdy;
    logic             wrdy;
    logic [15:0]      awa;
    logic [31:0]      wd;
    logic [3:0]       ws;
    logic             bv;
    logic [1:0]       br;
    logic             arrdy;
    logic [15:0]      ara;
    mqd_rph_t         rph;
    logic             rv;
    logic [31:0]      rd;
    logic [1:0]       rr;
    logic             ms_en;
    logic             pk;
    logic [NQ-1:0]    qen;
    logic [NQ*4-1:0]  ns;
    logic [NB*6-1:0]  src;
    logic [NEV-1:0]   stat;
    logic [NEV-1:0]   mask;
    logic             irq;
    mqd_eng_t         eng;
    logic [4:0]       q;
    logic [2:0]       k;
    logic [5:0]       idx;
    logic [NI*DW-1:0] ival;
    logic [NQ*2-1:0]  res;
    logic [NB-1:0]    lbits;
    logic             lstb;
  } mqd_state_t;

  mqd_state_t     s_r;
  mqd_state_t     s_nxt;
  logic [NQ-1:0]  qon;
  logic [5:0]     st [NQ];
  logic [NI-1:0]  imask [NQ];
  logic [NQ-1:0]  avail;
  logic [5:0]     tot;
  logic [5:0]     acc;
  logic [5:0]     oth;
  logic           ns_ok;
  logic           cfg_ok;
  logic [31:0]    pct;
  logic [3:0]     dq;
  logic [DW-1:0]  iv;
  logic           fire_w;
  logic           rd_clr;
  logic [NEV-1:0] ev;
  logic [5:0]     pos;
  logic [3:0]     nib;

  mqd_mem_if mem ();

  mqd_store u_store (
    .sys_clk_in (sys_clk_in),
    .port       (mem)
  );

  // Byte-lane merge of a write
  function automatic logic [31:0] bmerge(input logic [31:0] o, input logic [31:0] w,
                                         input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        o[b*8 +: 8] = w[b*8 +: 8];
      end
    end
    return o;
  endfunction

  // Link bit source decode
  function automatic logic pick(input logic [5:0] c, input logic [NQ*2-1:0] rv);
    if (c == SRC_FIX1) return 1'b1;
    if (c >= SRC_FIX0) return 1'b0;
    if (c >= SRC_HI_FIRST && !LARGE_CFG) return 1'b0;
    return rv[c[4:0]];
  endfunction

  // Integrator allocation, ascending qudit order
  always_comb begin
    acc = '0;
    ns_ok = 1'b1;
    oth = '0;
    for (int i = 0; i < NQ; i++) begin
      qon[i] = s_r.qen[i] && (LARGE_CFG || i < NQ / 2);
      st[i] = acc;
      ns_ok = ns_ok && s_r.ns[i*4 +: 4] >= QS_MIN && s_r.ns[i*4 +: 4] <= QS_MAX;
      if (qon[i]) begin
        acc = acc + 6'(need(s_r.ns[i*4 +: 4]));
      end
    end
    tot = acc;
    for (int i = 0; i < NQ; i++) begin
      oth = tot - (qon[i] ? 6'(need(s_r.ns[i*4 +: 4])) : 6'h0);
      avail[i] = oth + 6'(need(s_r.ns[i*4 +: 4])) <= 6'(NI);
      for (int j = 0; j < NI; j++) begin
        imask[i][j] = qon[i] && 6'(j) >= st[i]
                      && 6'(j) < st[i] + 6'(need(s_r.ns[i*4 +: 4]));
      end
    end
  end

  assign cfg_ok = tot <= 6'(NI);
  assign pct = 32'(tot) * 32'(PCT_SCALE) / 32'(NI);

  // Bus slave, discrimination engine, status
  always_comb begin
    s_nxt = s_r;
    mem.we = 1'b0;
    mem.addr = '0;
    mem.wdata = '0;
    ev = '0;
    rd_clr = 1'b0;
    pos = '0;
    nib = '0;
    dq = s_r.ns[s_r.q[3:0]*4 +: 4];
    iv = s_r.ival[(st[s_r.q[3:0]] + 6'(thr_src(dq, s_r.k))) * DW +: DW];

    // Write address and data, either order
    if (s_r.awrdy && s_axi_awvalid_in) begin
      s_nxt.awa = s_axi_awaddr_in;
      s_nxt.awrdy = 1'b0;
    end
    if (s_r.wrdy && s_axi_wvalid_in) begin
      s_nxt.wd = s_axi_wdata_in;
      s_nxt.ws = s_axi_wstrb_in;
      s_nxt.wrdy = 1'b0;
    end
    if (s_r.bv && s_axi_bready_in) begin
      s_nxt.bv = 1'b0;
    end
    fire_w = !s_r.awrdy && !s_r.wrdy && !s_r.bv
             && (!s_r.awa[MEM_BIT] || s_r.eng == E_IDLE);
    if (fire_w) begin
      s_nxt.bv = 1'b1;
      s_nxt.awrdy = 1'b1;
      s_nxt.wrdy = 1'b1;
      s_nxt.br = RESP_OK;
      if (s_r.awa[MEM_BIT]) begin
        // Thresholds, assignment vectors, weights
        mem.we = |s_r.ws[1:0] && !srst_in;
        mem.addr = s_r.awa[MAW+1:2];
        mem.wdata = s_r.wd[DW-1:0];
      end else if (is_page(s_r.awa, P_SRC)) begin
        if (!s_r.pk && s_r.ws[0]) begin
          s_nxt.src[s_r.awa[5:2]*6 +: 6] = s_r.wd[5:0];
        end
      end else if (!is_page(s_r.awa, P_QINFO)) begin
        case (s_r.awa)
          A_CTRL: begin
            if (s_r.ws[0]) begin
              s_nxt.ms_en = s_r.wd[CTRL_MS];
              s_nxt.pk = s_r.wd[CTRL_PK];
            end
          end
          A_QEN: s_nxt.qen = NQ'(bmerge(32'(s_r.qen), s_r.wd, s_r.ws));
          A_NS_LO, A_NS_HI: begin
            for (int i = 0; i < NQ / 2; i++) begin
              nib = s_r.wd[i*4 +: 4];
              if (s_r.ws[i/2] && nib >= QS_MIN && nib <= QS_MAX) begin
                s_nxt.ns[(s_r.awa[2] ? NQ * 2 : 0) + i*4 +: 4] = nib;
              end
            end
          end
          A_IMASK: s_nxt.mask = NEV'(bmerge(32'(s_r.mask), s_r.wd, s_r.ws));
          A_CNT, A_PCT, A_AVAIL, A_VALID, A_ISTAT, A_RES: s_nxt.br = RESP_OK;
          default: s_nxt.br = RESP_ERR;
        endcase
      end
    end

    // Read channel
    case (s_r.rph)
      R_IDLE: begin
        if (s_axi_arvalid_in) begin
          s_nxt.ara = s_axi_araddr_in;
          s_nxt.arrdy = 1'b0;
          s_nxt.rph = R_DEC;
        end
      end
      R_DEC: begin
        if (s_r.ara[MEM_BIT]) begin
          if (s_r.eng == E_IDLE && !(fire_w && s_r.awa[MEM_BIT])) begin
            mem.addr = s_r.ara[MAW+1:2];
            s_nxt.rph = R_WAIT;
          end
        end else begin
          s_nxt.rv = 1'b1;
          s_nxt.rph = R_RESP;
          s_nxt.rr = RESP_OK;
          s_nxt.rd = '0;
          if (is_page(s_r.ara, P_QINFO)) begin
            s_nxt.rd = {imask[s_r.ara[5:2]], 10'h0, st[s_r.ara[5:2]]};
          end else if (is_page(s_r.ara, P_SRC)) begin
            s_nxt.rd = 32'(s_r.src[s_r.ara[5:2]*6 +: 6]);
          end else begin
            case (s_r.ara)
              A_CTRL:  s_nxt.rd = 32'({s_r.pk, s_r.ms_en});
              A_QEN:   s_nxt.rd = 32'(s_r.qen);
              A_NS_LO: s_nxt.rd = s_r.ns[31:0];
              A_NS_HI: s_nxt.rd = s_r.ns[63:32];
              A_CNT:   s_nxt.rd = 32'(tot);
              A_PCT:   s_nxt.rd = pct;
              A_AVAIL: s_nxt.rd = 32'(avail);
              A_VALID: s_nxt.rd = 32'(cfg_ok);
              A_ISTAT: begin
                s_nxt.rd = 32'(s_r.stat);
                rd_clr = 1'b1;
              end
              A_IMASK: s_nxt.rd = 32'(s_r.mask);
              A_RES:   s_nxt.rd = s_r.res;
              default: s_nxt.rr = RESP_ERR;
            endcase
          end
        end
      end
      R_WAIT: begin
        s_nxt.rd = 32'(mem.rdata);
        s_nxt.rv = 1'b1;
        s_nxt.rr = RESP_OK;
        s_nxt.rph = R_RESP;
      end
      R_RESP: begin
        if (s_axi_rready_in) begin
          s_nxt.rv = 1'b0;
          s_nxt.arrdy = 1'b1;
          s_nxt.rph = R_IDLE;
        end
      end
      default: s_nxt.rph = R_IDLE;
    endcase

    // Discrimination engine
    s_nxt.lstb = 1'b0;
    case (s_r.eng)
      E_IDLE: begin
        if (int_valid_in && s_r.ms_en) begin
          if (!cfg_ok) begin
            ev[EV_REFUSE] = 1'b1;
          end else begin
            s_nxt.ival = int_val_in;
            s_nxt.q = '0;
            s_nxt.eng = E_NEXT;
          end
        end
      end
      E_NEXT: begin
        if (s_r.q[4]) begin
          s_nxt.eng = E_OUT;
        end else if (!qon[s_r.q[3:0]]) begin
          s_nxt.res[s_r.q[3:0]*2 +: 2] = 2'h0;
          s_nxt.q = s_r.q + 5'h1;
        end else begin
          s_nxt.k = '0;
          s_nxt.idx = '0;
          s_nxt.eng = E_THR;
        end
      end
      E_THR: begin
        mem.addr = mem_a(s_r.q[3:0], MR_THR, {3'h0, s_r.k});
        s_nxt.eng = E_CMP;
      end
      E_CMP: begin
        s_nxt.idx[s_r.k] = $signed(iv) > $signed(mem.rdata);
        if (s_r.k + 3'h1 < n_thr(dq)) begin
          s_nxt.k = s_r.k + 3'h1;
          s_nxt.eng = E_THR;
        end else begin
          s_nxt.eng = E_ASG;
        end
      end
      E_ASG: begin
        mem.addr = mem_a(s_r.q[3:0], MR_ASG, s_r.idx);
        s_nxt.eng = E_AWT;
      end
      E_AWT: begin
        s_nxt.res[s_r.q[3:0]*2 +: 2] = mem.rdata[1:0];
        s_nxt.q = s_r.q + 5'h1;
        s_nxt.eng = E_NEXT;
      end
      E_OUT: begin
        for (int p = 0; p < NB; p++) begin
          s_nxt.lbits[p] = pick(s_r.src[p*6 +: 6], s_r.res);
        end
        if (s_r.pk) begin
          s_nxt.lbits = '0;
          for (int i = 0; i < NQ; i++) begin
            for (int b = 0; b < 2; b++) begin
              if (qon[i] && 2'(b) < nbits(s_r.ns[i*4 +: 4])) begin
                if (pos < 6'(NB)) begin
                  s_nxt.lbits[pos[3:0]] = s_r.res[i*2 + b];
                end
                pos = pos + 6'h1;
              end
            end
          end
        end
        s_nxt.lstb = 1'b1;
        ev[EV_DONE] = 1'b1;
        s_nxt.eng = E_IDLE;
      end
      default: s_nxt.eng = E_IDLE;
    endcase
    if (int_valid_in && s_r.eng != E_IDLE) begin
      ev[EV_DROP] = 1'b1;
    end

    // Sticky status, read clears, set wins
    s_nxt.stat = (rd_clr ? '0 : s_r.stat) | ev;
    s_nxt.irq = |(s_nxt.stat & s_nxt.mask);

    // Synchronous reset
    if (srst_in) begin
      s_nxt = '0;
      s_nxt.awrdy = 1'b1;
      s_nxt.wrdy = 1'b1;
      s_nxt.arrdy = 1'b1;
      s_nxt.ns = {NQ{QS_MIN}};
      for (int p = 0; p < NB; p++) begin
        s_nxt.src[p*6 +: 6] = 6'(p);
      end
    end
  end

  // State register
  always_ff @(posedge sys_clk_in) begin
    s_r <= s_nxt;
  end

  // Outputs straight from the state register
  assign s_axi_awready_out = s_r.awrdy;
  assign s_axi_wready_out = s_r.wrdy;
  assign s_axi_bvalid_out = s_r.bv;
  assign s_axi_bresp_out = s_r.br;
  assign s_axi_arready_out = s_r.arrdy;
  assign s_axi_rvalid_out = s_r.rv;
  assign s_axi_rdata_out = s_r.rd;
  assign s_axi_rresp_out = s_r.rr;
  assign link_bits_out = s_r.lbits;
  assign link_strobe_out = s_r.lstb;
  assign irq_out = s_r.irq;

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (srst_in);

  chk_pack_ro: assert property (s_r.pk && fire_w && is_page(s_r.awa, P_SRC)
    |=> $stable(s_r.src)) else $error("bit source changed in packed mode");
  chk_mode_gate: assert property (s_r.eng == E_IDLE && !s_r.ms_en
    |=> s_r.eng == E_IDLE) else $error("engine started with mode off");
  chk_ns_range: assert property (ns_ok)
    else $error("state count outside 2..4");
  chk_valid_read: assert property (s_r.rph == R_DEC && s_r.ara == A_VALID
    |=> s_r.rd == 32'($past(tot) <= 6'(NI))) else $error("valid flag wrong");
  chk_pct_value: assert property (pct * 32'(NI) <= 32'(tot) * 32'(PCT_SCALE)
    && 32'(tot) * 32'(PCT_SCALE) < (pct + 32'h1) * 32'(NI)) else $error("bad percent");
  chk_thr_limit: assert property (s_r.eng == E_CMP |-> s_r.k < n_thr(dq))
    else $error("threshold beyond d(d-1)/2 used");
  chk_out_pulse: assert property (s_r.eng == E_OUT
    |=> s_r.lstb ##1 !s_r.lstb) else $error("result strobe not one cycle");
  chk_small_src: assert property (!LARGE_CFG && s_r.eng == E_OUT && !s_r.pk
    && s_r.src[17:12] >= SRC_HI_FIRST && s_r.src[17:12] < SRC_FIX0
    |=> !s_r.lbits[2]) else $error("upper qudit code honoured");
  chk_pack_first: assert property (s_r.eng == E_OUT && s_r.pk && qon[0]
    |=> s_r.lbits[0] == $past(s_r.res[0])) else $error("packed bit 0 wrong");
endmodule // mqd_top

// >>> verif/mqd_fb_model.sv
`timescale 1ns/100ps
// Feedback controller end: latches each result word on its strobe
module mqd_fb_model
  import mqd_pkg::*;
(
  input  wire logic          sys_clk_in,
  input  wire logic          srst_in,
  input  wire logic [NB-1:0] link_bits_in,
  input  wire logic          link_strobe_in,
  output logic [NB-1:0]      word_out,
  output int                 frames_out
);
  // Bits between strobes are not trusted, so only the strobe cycle counts
  always @(posedge sys_clk_in) begin
    if (srst_in) begin
      word_out   <= '0;
      frames_out <= 0;
    end else if (link_strobe_in) begin
      word_out   <= link_bits_in;
      frames_out <= frames_out + 1;
    end
  end
endmodule // mqd_fb_model

// >>> verif/tb_multistate_qudit_discriminator.sv
`timescale 1ns/100ps
module tb_multistate_qudit_discriminator;
  import mqd_pkg::*;
  logic             clk, srst;
  logic [15:0]      awaddr, araddr;
  logic [31:0]      wdata, rdata, d;
  logic             awvalid, awready, wvalid, wready, bvalid, bready;
  logic             arvalid, arready, rvalid, rready;
  logic [1:0]       bresp, rresp, r, br;
  logic [NI*DW-1:0] ival;
  logic             itrig, lstb, irq;
  logic [NB-1:0]    lbits, fword;
  int               frames, mismatches, n_tests;

  mqd_top #(.LARGE_CFG(1'b0)) DUT (
    .sys_clk_in(clk), .srst_in(srst),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .int_val_in(ival), .int_valid_in(itrig),
    .link_bits_out(lbits), .link_strobe_out(lstb), .irq_out(irq)
  );

  mqd_fb_model FB (
    .sys_clk_in(clk), .srst_in(srst), .link_bits_in(lbits), .link_strobe_in(lstb),
    .word_out(fword), .frames_out(frames)
  );

  // Free-running system clock
  always #12.5 clk = ~clk;

  // Value check and tally
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    if (mismatches == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Bus write: address and data offered together, each dropped when taken
  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    int t;
    t = 0;
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do begin
      @(posedge clk);
      t++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && t < 300);
    br = bresp;
    if (t >= 300) mismatches++;
  endtask

  // Bus read: data and response taken at the edge rvalid is seen
  task automatic rd(input logic [15:0] a, output logic [31:0] v, output logic [1:0] rs);
    int t;
    t = 0;
    araddr  <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clk);
      t++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && t < 300);
    v = rdata;
    rs = rresp;
    if (t >= 300) mismatches++;
  endtask

  task automatic rc(input logic [15:0] a, input logic [31:0] e);
    logic [31:0] v;
    logic [1:0]  rs;
    rd(a, v, rs);
    chk(v, e);
  endtask

  // Store window byte address of word {qudit, region, index}
  function automatic logic [15:0] sa(input int q, input logic [1:0] rg, input int i);
    return {2'b01, 4'(q), rg, 6'(i), 2'b00};
  endfunction

  // Trigger held n cycles, then wait up to lim cycles for a frame
  task automatic trig(input int n, input int lim, input int exp);
    int f0, t;
    f0 = frames;
    t = 0;
    itrig <= 1'b1;
    repeat (n) @(posedge clk);
    itrig <= 1'b0;
    while (frames == f0 && t < lim) begin
      @(posedge clk);
      t++;
    end
    chk(32'(frames - f0), 32'(exp));
  endtask

  // Watchdog well past the expected run length
  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    conclude();
  end

  // Main sequence
  initial begin
    int dq, nt;
    automatic int vals[6] = '{5, 5, -5, -5, 5, 5};
    automatic logic [31:0] info[3] = '{32'h00010000, 32'h00060001, 32'h00380003};
    clk = 0; srst = 1; awaddr = '0; araddr = '0; wdata = '0; awvalid = 0; wvalid = 0;
    bready = 1; arvalid = 0; rready = 1; ival = '0; itrig = 0; // Readies held high all run
    mismatches = 0; n_tests = 0;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rc(A_CTRL, 32'h0);
    rc(A_QEN, 32'h0);
    rc(A_NS_LO, 32'h22222222);
    rc(A_CNT, 32'h0);
    rc(A_VALID, 32'h1);
    rc(16'h0214, 32'h5);
    rc(A_IMASK, 32'h0);
    rd(16'h002c, d, r);
    chk(32'(r), 32'(RESP_ERR));
    wr(16'h002c, 32'h1);
    chk(32'(br), 32'(RESP_ERR));
    wr(A_CNT, 32'h5);
    chk(32'(br), 32'(RESP_OK));
    rc(A_CNT, 32'h0);
    // Integrator results: signs pick the comparison outcomes
    for (int i = 0; i < 6; i++) ival[16*i +: 16] <= 16'(vals[i]);
    wr(A_QEN, 32'h7);
    trig(1, 150, 0);
    wr(A_NS_LO, 32'h22225432);
    rc(A_NS_LO, 32'h22222432);
    rc(A_CNT, 32'h6);
    rc(A_PCT, 32'h25);
    rc(A_VALID, 32'h1);
    rc(A_AVAIL, 32'hffff);
    for (int q = 0; q < 3; q++) rc(16'h0100 + 16'(4 * q), info[q]);
    // Thresholds past d(d-1)/2 are set so high that using them would show
    for (int q = 0; q < 3; q++) begin
      dq = q + 2;
      nt = dq * (dq - 1) / 2;
      for (int k = 0; k < 6; k++) wr(sa(q, MR_THR, k), (k < nt) ? 32'h0 : 32'h7fff);
      for (int i = 0; i < (1 << nt); i++) wr(sa(q, MR_ASG, i), 32'(i % dq));
    end
    wr(sa(2, MR_WGT, 5), 32'hffff8000);
    rc(sa(2, MR_WGT, 5), 32'h00008000);
    wr(A_IMASK, 32'h7);
    wr(A_CTRL, 32'h1);
    trig(1, 400, 1);
    chk(32'(fword), 32'h29);
    rc(A_RES, 32'h29);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h1);
    rc(A_ISTAT, 32'h1);
    rc(A_ISTAT, 32'h0);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0);
    // Explicit sources, fixed level and a large-build code
    wr(16'h0200, 32'h21);
    wr(16'h0204, 32'h5);
    wr(16'h0208, 32'h10);
    trig(2, 400, 1);
    chk(32'(fword), 32'h2b);
    rc(A_ISTAT, 32'h5);
    // Compact packing locks the source table
    wr(A_CTRL, 32'h3);
    wr(16'h0200, 32'h20);
    chk(32'(br), 32'(RESP_OK));
    rc(16'h0200, 32'h21);
    trig(1, 400, 1);
    chk(32'(fword), 32'h15);
    rc(A_ISTAT, 32'h1);
    // Over-committed set: refused trigger
    wr(A_NS_LO, 32'h44444444);
    wr(A_QEN, 32'hff);
    rc(A_CNT, 32'h18);
    rc(A_PCT, 32'h96);
    rc(A_VALID, 32'h0);
    rd(A_AVAIL, d, r);
    chk(32'(d[7:0]), 32'h0);
    trig(1, 150, 0);
    rc(A_ISTAT, 32'h2);
    conclude();
  end
endmodule // tb_multistate_qudit_discriminator
